// [hdl/liu_ctrl_pkg.sv]
// Package: register map, field layout and loss-of-signal counts for the global control bank
//--------------------------------------------------------------
// Overview of operation
// - Rate bit 0 gives E1, 1 gives T1/J1
// - Mute bit silences data outputs during loss
// - Long loss bit: declare after 4096 zeros
// - Otherwise 175+75 zeros T1, 32 zeros E1
// - Test bit floats every output pin
// - Test bit or low test pin float
//--------------------------------------------------------------
package liu_ctrl_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // Register offsets on the parallel port
    localparam logic [6:0] CLK_LOS_CTRL_OFFSET = 7'h41;
    localparam logic [6:0] GAUGE_TX_CTRL_OFFSET = 7'h42;
    localparam logic [6:0] LOS_STATUS_OFFSET = 7'h43;

    localparam logic [7:0] CLK_LOS_CTRL_RESET = 8'h00;
    localparam logic [7:0] GAUGE_TX_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLK_LOS_CTRL_MASK = 8'h3f;

    // Field positions in the clock and loss control register
    localparam int BOARD_TEST_FLOAT_BIT = 0;
    localparam int LONG_LOSS_COUNT_BIT = 1;
    localparam int RX_SILENCE_BIT = 2;
    localparam int SYNTH_RATE_BIT = 3;
    localparam int SYNTH_IN_B0_BIT = 4;
    localparam int SYNTH_IN_B1_BIT = 5;

    // Field positions in the gauge and transmit control register
    localparam int TERM_SRC_BIT = 4;
    localparam int TXON_SRC_BIT = 5;
    localparam int WIRE_B0_BIT = 6;
    localparam int WIRE_B1_BIT = 7;

    // Zero counts before loss is declared
    localparam int LOS_LONG_BITS = 4096;
    localparam int LOS_T1_BITS = 175 + 75;
    localparam int LOS_E1_BITS = 32;

    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic pos;
        logic neg;
    } rx_pair_t;

endpackage

// [hdl/los_zero_counter.sv]
// Module: one channel's consecutive-zero counter and loss-of-signal flag
`timescale 1ns/1ps
module los_zero_counter
    import liu_ctrl_pkg::*;
#(
    parameter int CNT_W = 13
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic bitStrobe,
    input wire rx_pair_t rxIn,
    input wire logic [CNT_W-1:0] threshold,
    output logic lossFlag
);

    logic [CNT_W-1:0] zeroCnt_r;
    logic [CNT_W-1:0] zeroCnt_nxt;
    logic lossFlag_r;
    logic lossFlag_nxt;
    wire markSeen = rxIn.pos | rxIn.neg;
    wire atLimit = (zeroCnt_r >= threshold);
    wire [CNT_W-1:0] cntInc = zeroCnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

    // The increment constant needs at least one padding bit
    if (CNT_W < 2)
    begin : gWidthCheck
        $error("CNT_W must be at least 2");
    end

    // Counter saturates at the threshold so a long run cannot wrap and clear loss
    assign zeroCnt_nxt = markSeen ? '0 : (atLimit ? zeroCnt_r : cntInc);
    assign lossFlag_nxt = !markSeen && (zeroCnt_nxt >= threshold);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            zeroCnt_r <= '0;
            lossFlag_r <= 1'b0;
        end
        else if (ce && bitStrobe)
        begin
            zeroCnt_r <= zeroCnt_nxt;
            lossFlag_r <= lossFlag_nxt;
        end
    end

    assign lossFlag = lossFlag_r;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    AST_LOSS_AT_COUNT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && bitStrobe && !markSeen && cntInc == threshold) |=> lossFlag)
        else $error("loss not declared at zero threshold");

    AST_MARK_CLEARS: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && bitStrobe && markSeen) |=> (!lossFlag && zeroCnt_r == '0))
        else $error("mark did not clear loss");

endmodule

// [hdl/liu_global_control_regs.sv]
// Module: global control bank with per-channel loss detection and output muting
`timescale 1ns/1ps
module liu_global_control_regs
    import liu_ctrl_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int LONG_LOS_BITS = LOS_LONG_BITS
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [DATA_W-1:0] regWrData,
    output logic [DATA_W-1:0] regRdData,
    input wire logic boardTestPin_n,
    input wire logic [CHANNELS-1:0] rxBitStrobe,
    input wire rx_pair_t [CHANNELS-1:0] rxIn,
    output rx_pair_t [CHANNELS-1:0] rxOut,
    output logic [CHANNELS-1:0] receiveSignalLoss,
    output logic outputsFloat,
    output logic synthRateSelect,
    output logic [1:0] synthInputSelect,
    output logic [1:0] wireSizeSelect,
    output logic transmitOnSourceSelect,
    output logic terminationSourceSelect,
    output logic [3:0] rxFrontEndTrim
);

    localparam int CNT_W = $clog2(LONG_LOS_BITS + 1);

    //--------------------------------------------------------------
    // Parameter checks
    //--------------------------------------------------------------
    if (CHANNELS < 1 || CHANNELS > DATA_W)
    begin : gChanCheck
        $error("CHANNELS must be 1 to 8");
    end
    if (LONG_LOS_BITS <= LOS_T1_BITS)
    begin : gLosCheck
        $error("LONG_LOS_BITS must exceed the T1 count");
    end

    //--------------------------------------------------------------
    // Register port
    //--------------------------------------------------------------
    logic [DATA_W-1:0] clkLosCtrl_r;
    logic [DATA_W-1:0] gaugeTxCtrl_r;
    logic [DATA_W-1:0] regRdData_r;
    logic [DATA_W-1:0] rdMux;
    logic [DATA_W-1:0] losStatus;

    function automatic logic hitAddr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hitAddr = (a == off);
    endfunction

    wire wrClkLos = ce && regWrEn && hitAddr(regAddr, CLK_LOS_CTRL_OFFSET);
    wire wrGauge = ce && regWrEn && hitAddr(regAddr, GAUGE_TX_CTRL_OFFSET);

    // Unmapped addresses read as zero
    assign rdMux = hitAddr(regAddr, CLK_LOS_CTRL_OFFSET) ? clkLosCtrl_r :
                   hitAddr(regAddr, GAUGE_TX_CTRL_OFFSET) ? gaugeTxCtrl_r :
                   hitAddr(regAddr, LOS_STATUS_OFFSET) ? losStatus : 8'h00;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            clkLosCtrl_r <= CLK_LOS_CTRL_RESET;
        else if (wrClkLos)
            clkLosCtrl_r <= regWrData & CLK_LOS_CTRL_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            gaugeTxCtrl_r <= GAUGE_TX_CTRL_RESET;
        else if (wrGauge)
            gaugeTxCtrl_r <= regWrData;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            regRdData_r <= 8'h00;
        else if (ce && regRdEn)
            regRdData_r <= rdMux;
    end

    assign regRdData = regRdData_r;

    //--------------------------------------------------------------
    // Control field decode
    //--------------------------------------------------------------
    wire testFloatBit = clkLosCtrl_r[BOARD_TEST_FLOAT_BIT];
    wire longLossEn = clkLosCtrl_r[LONG_LOSS_COUNT_BIT];
    wire rxSilenceEn = clkLosCtrl_r[RX_SILENCE_BIT];

    assign synthRateSelect = clkLosCtrl_r[SYNTH_RATE_BIT];
    assign synthInputSelect = {clkLosCtrl_r[SYNTH_IN_B1_BIT], clkLosCtrl_r[SYNTH_IN_B0_BIT]};
    assign wireSizeSelect = {gaugeTxCtrl_r[WIRE_B1_BIT], gaugeTxCtrl_r[WIRE_B0_BIT]};
    assign transmitOnSourceSelect = gaugeTxCtrl_r[TXON_SRC_BIT];
    assign terminationSourceSelect = gaugeTxCtrl_r[TERM_SRC_BIT];
    assign rxFrontEndTrim = gaugeTxCtrl_r[3:0];

    //--------------------------------------------------------------
    // Test pin synchroniser and float control
    //--------------------------------------------------------------
    logic [SYNC_STAGES-1:0] pinSync_r;
    logic hwFloat_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pinSync_r <= '1;
        else if (ce)
            pinSync_r <= {pinSync_r[SYNC_STAGES-2:0], boardTestPin_n};
    end

    // A change is taken only once the last two stages agree
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            hwFloat_r <= 1'b0;
        else if (ce && pinSync_r[1] == pinSync_r[2])
            hwFloat_r <= !pinSync_r[2];
    end

    // Either source alone floats the pins; the pad ring applies it as the enable
    assign outputsFloat = testFloatBit || hwFloat_r;

    //--------------------------------------------------------------
    // Loss detection and receive muting per channel
    //--------------------------------------------------------------
    logic [CNT_W-1:0] losThreshold;
    logic [CHANNELS-1:0] lossFlag;
    rx_pair_t [CHANNELS-1:0] rxOut_r;

    // Line mode follows the synthesizer rate: 1 is T1/J1, 0 is E1
    assign losThreshold = longLossEn ? CNT_W'(LONG_LOS_BITS) :
                          (synthRateSelect ? CNT_W'(LOS_T1_BITS) : CNT_W'(LOS_E1_BITS));

    assign losStatus = DATA_W'(lossFlag);

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : gChan
            wire silence = rxSilenceEn && lossFlag[ch];

            los_zero_counter #(
                .CNT_W(CNT_W)
            ) uCounter (
                .clk(clk),
                .sys_rst(sys_rst),
                .ce(ce),
                .bitStrobe(rxBitStrobe[ch]),
                .rxIn(rxIn[ch]),
                .threshold(losThreshold),
                .lossFlag(lossFlag[ch])
            );

            // Only data is forced low; the recovered clock is not routed here
            rx_pair_t rxOutCh_r;

            always_ff @(posedge clk)
            begin
                if (sys_rst)
                    rxOutCh_r <= '0;
                else if (ce)
                    rxOutCh_r <= silence ? '0 : rxIn[ch];
            end

            // One register per channel keeps a single writer for each flop
            assign rxOut_r[ch] = rxOutCh_r;

            AST_MUTE_ON_LOSS: assert property (
                @(posedge clk) disable iff (sys_rst)
                (ce && rxSilenceEn && lossFlag[ch]) |=> (rxOut[ch] == '0))
                else $error("receive output not muted during loss");

            AST_PASS_WITHOUT_LOSS: assert property (
                @(posedge clk) disable iff (sys_rst)
                (ce && !lossFlag[ch]) |=> (rxOut[ch] == $past(rxIn[ch])))
                else $error("receive data altered without loss");

            AST_PASS_WHEN_UNMUTED: assert property (
                @(posedge clk) disable iff (sys_rst)
                (ce && !rxSilenceEn) |=> (rxOut[ch] == $past(rxIn[ch])))
                else $error("receive data altered while mute off");
        end
    endgenerate

    assign rxOut = rxOut_r;
    assign receiveSignalLoss = lossFlag;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    AST_RATE_FOLLOWS_WRITE: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrClkLos |=> (synthRateSelect == $past(regWrData[SYNTH_RATE_BIT])))
        else $error("rate select did not follow write");

    AST_LONG_THRESHOLD: assert property (
        @(posedge clk) disable iff (sys_rst)
        longLossEn |-> (losThreshold == CNT_W'(LONG_LOS_BITS)))
        else $error("long loss threshold wrong");

    AST_NORMAL_THRESHOLD: assert property (
        @(posedge clk) disable iff (sys_rst)
        !longLossEn |-> (losThreshold == (synthRateSelect ? CNT_W'(250) : CNT_W'(32))))
        else $error("normal loss threshold wrong");

    AST_FLOAT_BY_BIT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wrClkLos && regWrData[BOARD_TEST_FLOAT_BIT]) |=> outputsFloat)
        else $error("test bit did not float outputs");

    AST_FLOAT_BY_PIN: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !boardTestPin_n)[*4] |=> outputsFloat)
        else $error("test pin did not float outputs");

    AST_NO_FLOAT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && boardTestPin_n)[*4] |=> (outputsFloat == testFloatBit))
        else $error("outputs floated with no source");

endmodule

// [test/host_model.sv]
// Host processor model driving the parallel register port
`timescale 1ns/1ps
module host_model
    import liu_ctrl_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [DATA_W-1:0] regWrData
);
    initial
    begin
        regAddr = 7'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
    end
    // One strobe cycle per access; released lines show inverted values, never stale ones
    task automatic access(input logic [6:0] a, input logic [7:0] d, input logic w);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = w;
        regRdEn = !w;
        @(negedge clk);
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the global control bank
`timescale 1ns/1ps
module tb_top;
    import liu_ctrl_pkg::*;
    // Shortened long count keeps the run brief; must stay above the T1 count
    localparam int LONG_N = 300;
    logic clk, sys_rst, ce, regWrEn, regRdEn, boardTestPin_n, outputsFloat;
    logic rdSeen = 1'b0;
    logic synthRateSelect, transmitOnSourceSelect, terminationSourceSelect;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, wData, gData;
    logic [3:0] rxBitStrobe, receiveSignalLoss, rxFrontEndTrim;
    logic [1:0] synthInputSelect, wireSizeSelect;
    rx_pair_t [3:0] rxIn, rxOut;
    logic [15:0] lfsr = 16'h5702;
    logic [7:0] expQ[$];
    int n_mismatch = 0, compares = 0, cycles = 0;
    liu_global_control_regs #(.CHANNELS(4), .LONG_LOS_BITS(LONG_N)) liu_global_control_regs_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .boardTestPin_n(boardTestPin_n), .rxBitStrobe(rxBitStrobe), .rxIn(rxIn),
        .rxOut(rxOut), .receiveSignalLoss(receiveSignalLoss), .outputsFloat(outputsFloat),
        .synthRateSelect(synthRateSelect), .synthInputSelect(synthInputSelect),
        .wireSizeSelect(wireSizeSelect), .transmitOnSourceSelect(transmitOnSourceSelect),
        .terminationSourceSelect(terminationSourceSelect), .rxFrontEndTrim(rxFrontEndTrim));
    host_model host_model_i (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    //--------------------------------------------------------------
    // Scoreboard: read data is checked half a cycle after the read edge
    //--------------------------------------------------------------
    always @(posedge clk)
    begin
        rdSeen <= regRdEn && ce;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    always @(negedge clk)
        if (rdSeen)
            check(regRdData, expQ.pop_front());
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_model_i.access(a, d, 1'b1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        host_model_i.access(a, 8'h00, 1'b0);
    endtask
    task automatic strobe(input int n, input rx_pair_t v);
        repeat (n)
        begin
            @(negedge clk);
            rxIn[0] = v;
            rxBitStrobe[0] = 1'b1;
        end
        @(negedge clk);
        rxBitStrobe[0] = 1'b0;
        rxIn[0] = 2'b00;
    endtask
    task automatic los_case(input logic [7:0] ctl, input int n);
        wr(CLK_LOS_CTRL_OFFSET, ctl);
        check(synthRateSelect, ctl[SYNTH_RATE_BIT]);
        strobe(1, 2'b10);
        strobe(n - 1, 2'b00);
        check(receiveSignalLoss, 4'b0000);
        strobe(1, 2'b00);
        check(receiveSignalLoss, 4'b0001);
    endtask
    task automatic drive_rx(input rx_pair_t v);
        @(negedge clk);
        rxIn[0] = v;
        gData = rnd();
        rxIn[1] = gData[1:0];
        repeat (2) @(negedge clk);
    endtask
    //--------------------------------------------------------------
    // Stimulus
    //--------------------------------------------------------------
    initial
    begin
        ce = 1'b1;
        sys_rst = 1'b1;
        boardTestPin_n = 1'b1;
        rxBitStrobe = '0;
        rxIn = '0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        rd(CLK_LOS_CTRL_OFFSET, CLK_LOS_CTRL_RESET);
        rd(GAUGE_TX_CTRL_OFFSET, GAUGE_TX_CTRL_RESET);
        check(outputsFloat, 1'b0);
        repeat (8)
        begin
            wData = rnd();
            wr(CLK_LOS_CTRL_OFFSET, wData);
            check(synthRateSelect, wData[SYNTH_RATE_BIT]);
            check(outputsFloat, wData[BOARD_TEST_FLOAT_BIT]);
            check(synthInputSelect, wData[5:4]);
            rd(CLK_LOS_CTRL_OFFSET, wData & CLK_LOS_CTRL_MASK);
            gData = rnd();
            wr(GAUGE_TX_CTRL_OFFSET, gData);
            check({wireSizeSelect, transmitOnSourceSelect, terminationSourceSelect,
                rxFrontEndTrim}, gData);
            rd(7'h50, 8'h00);
        end
        // Writes while the clock enable is low must leave the bank alone
        ce = 1'b0;
        wr(GAUGE_TX_CTRL_OFFSET, ~gData);
        ce = 1'b1;
        rd(GAUGE_TX_CTRL_OFFSET, gData);
        // A reset in mid-run must return both registers to their reset values
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        check(outputsFloat, 1'b0);
        rd(CLK_LOS_CTRL_OFFSET, CLK_LOS_CTRL_RESET);
        rd(GAUGE_TX_CTRL_OFFSET, GAUGE_TX_CTRL_RESET);
        los_case(8'h04, LOS_E1_BITS);
        drive_rx(2'b11);
        check(rxOut[0], 2'b00);
        check(rxOut[1], rxIn[1]);
        rd(LOS_STATUS_OFFSET, 8'h01);
        strobe(1, 2'b01);
        drive_rx(2'b01);
        check(rxOut[0], 2'b01);
        los_case(8'h00, LOS_E1_BITS);
        drive_rx(2'b11);
        check(rxOut[0], 2'b11);
        los_case(8'h0c, LOS_T1_BITS);
        los_case(8'h02, LONG_N);
        @(negedge clk);
        boardTestPin_n = 1'b0;
        repeat (5) @(negedge clk);
        check(outputsFloat, 1'b1);
        boardTestPin_n = 1'b1;
        repeat (5) @(negedge clk);
        check(outputsFloat, 1'b0);
        repeat (3) @(negedge clk);
        end_of_test();
    end
endmodule
